// ---- src/dtc_pkg.sv ----
// shared constants and types for the dual timer/counter pair
// assumes a 32-bit classic wishbone slave port and one 10 MHz core clock
package dtc_pkg;
    // register word indices (indices not multiples of four: byte address = 4 * index)
    localparam logic [7:0] DTC_IDX_RUN_CONTROL  = 8'h88;
    localparam logic [7:0] DTC_IDX_MODE_CONFIG  = 8'h89;
    localparam logic [7:0] DTC_IDX_U0_LOW       = 8'h8a;
    localparam logic [7:0] DTC_IDX_U1_LOW       = 8'h8b;
    localparam logic [7:0] DTC_IDX_U0_HIGH      = 8'h8c;
    localparam logic [7:0] DTC_IDX_U1_HIGH      = 8'h8d;
    localparam logic [7:0] DTC_IDX_IRQ_STATUS   = 8'h90;
    localparam logic [7:0] DTC_IDX_IRQ_ENABLE   = 8'h91;
    localparam logic [7:0] DTC_IDX_IRQ_CLEAR    = 8'h92;
    localparam int         DTC_ADDR_W           = 12;

    // reset values
    localparam logic [7:0] DTC_RUN_CONTROL_RST  = 8'h00;
    localparam logic [7:0] DTC_MODE_CONFIG_RST  = 8'h00;
    localparam logic [7:0] DTC_COUNT_RST        = 8'h00;

    // run control field positions
    localparam int DTC_RC_U1_OVF  = 7;
    localparam int DTC_RC_U1_RUN  = 6;
    localparam int DTC_RC_U0_OVF  = 5;
    localparam int DTC_RC_U0_RUN  = 4;
    // mode config field positions, per unit nibble
    localparam int DTC_MC_GATE    = 3;
    localparam int DTC_MC_CNT_SEL = 2;
    localparam int DTC_MC_MODE_HI = 1;
    localparam int DTC_MC_MODE_LO = 0;
    localparam int DTC_MC_U1_BASE = 4;
    localparam int DTC_MC_U0_BASE = 0;

    // machine cycle timing
    localparam int         DTC_CLOCK_HZ         = 10_000_000;
    localparam int         DTC_CYCLE_CLOCKS     = 12;
    localparam logic [3:0] DTC_PHASE_LAST       = 4'(DTC_CYCLE_CLOCKS - 1);
    localparam logic [3:0] DTC_PHASE_SAMPLE     = 4'h9;  // input_sample_phase slot
    localparam logic [3:0] DTC_PHASE_UPDATE     = 4'h4;  // count_update_phase slot
    localparam int         DTC_PRESCALE_BITS    = 5;

    typedef enum logic [1:0] {
        DTC_MODE_13BIT  = 2'b00,
        DTC_MODE_16BIT  = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT  = 2'b11
    } dtc_mode_t;

    // per-unit controls decoded from the nibble
    typedef struct packed {
        logic      gate;
        logic      cnt_sel;
        dtc_mode_t mode;
    } dtc_unit_cfg_t;

    // count pair of one unit
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dtc_count_t;
endpackage

// ---- src/dtc_edge_sampler.sv ----
// falling-edge detector for one external count pin
// assumes the pin is already synchronised to clock
`timescale 1ns/100ps
module dtc_edge_sampler
    import dtc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic sample_strobe,
    input  wire logic update_strobe,
    input  wire logic pin_sync,
    output logic      count_event
);
    logic cur_sample;
    logic pending;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur_sample <= 1'b0;
        end else if (sample_strobe) begin
            cur_sample <= pin_sync;  // last sample, compared with the next one
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pending <= 1'b0;
        end else if (sample_strobe) begin
            pending <= cur_sample & ~pin_sync;
        end else if (update_strobe) begin
            pending <= 1'b0;
        end
    end

    // one event per two machine cycles at most
    assign count_event = pending & update_strobe;
endmodule

// ---- src/dtc_timer_pair.sv ----
// two timer/counter units with run control, mode config and a wishbone slave
// assumes classic wishbone master on clock, pins asynchronous to clock
//
// Contract
// - timer counts once per 12-clock machine cycle
// - count pin sampled each cycle, falling edge
// - edge count appears next cycle update phase
// - counter input needs two machine cycles
// - gate bit needs gate pin high
// - select bit picks pin or internal clock
// - two-bit mode field per unit
// - mode 00: 5-bit prescaler then 8-bit
// - mode 01: full 16-bit counter
// - mode 10: low reloads from high
// - mode 11 stops unit 1
// - unit 0 mode 11 splits into two
// - overflow sets flag, vector clears it
// - run bit turns unit on/off
// - 13-bit count, top low bits indeterminate
// - reload leaves high byte unchanged
`timescale 1ns/100ps
module dtc_timer_pair
    import dtc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        count_pin_zero,
    input  wire logic        count_pin_one,
    input  wire logic        gate_pin_zero,
    input  wire logic        gate_pin_one,
    input  wire logic        vector_ack_zero,
    input  wire logic        vector_ack_one,
    output logic             unit0_overflow_flag,
    output logic             unit1_overflow_flag,
    output logic             irq
);
    logic        rst_meta;
    logic        rst_n;
    logic [3:0]  phase;
    logic        sample_strobe;
    logic        update_strobe;
    logic [3:0]  pin_meta;
    logic [3:0]  pin_sync;
    logic [7:0]  timer_run_control;
    logic [7:0]  timer_mode_config;
    dtc_count_t  cnt0;
    dtc_count_t  cnt1;
    logic [1:0]  irq_status;
    logic [1:0]  irq_enable;
    logic [1:0]  edge_evt;
    logic [1:0]  tick;
    logic [1:0]  run_ok;
    logic        ovf0_low;
    logic        ovf0_high;
    logic        ovf1;
    dtc_unit_cfg_t cfg0;
    dtc_unit_cfg_t cfg1;
    dtc_count_t  next_cnt0;
    dtc_count_t  next_cnt1;
    logic        wr_hit;
    logic        rd_hit;
    logic [9:0]  word_idx;
    logic        mapped;
    logic [7:0]  rd_byte;

    // reset release through two flops
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // pin synchronisers: count0, count1, gate0, gate1
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {gate_pin_one, gate_pin_zero, count_pin_one, count_pin_zero};
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= 4'h0;
        end else if (phase == DTC_PHASE_LAST) begin
            phase <= 4'h0;
        end else begin
            phase <= phase + 4'h1;
        end
    end
    assign sample_strobe = (phase == DTC_PHASE_SAMPLE);
    assign update_strobe = (phase == DTC_PHASE_UPDATE);

    // one edge sampler per unit
    for (genvar u = 0; u < 2; u++) begin : g_edge
        dtc_edge_sampler u_edge (
            .clock         (clock),
            .rst_n         (rst_n),
            .sample_strobe (sample_strobe),
            .update_strobe (update_strobe),
            .pin_sync      (pin_sync[u]),
            .count_event   (edge_evt[u])
        );
    end

    assign cfg0 = dtc_unit_cfg_t'(timer_mode_config[DTC_MC_U0_BASE +: 4]);
    assign cfg1 = dtc_unit_cfg_t'(timer_mode_config[DTC_MC_U1_BASE +: 4]);

    // gating by pin and run bit
    assign run_ok[0] = timer_run_control[DTC_RC_U0_RUN] & (~cfg0.gate | pin_sync[2]);
    assign run_ok[1] = timer_run_control[DTC_RC_U1_RUN] & (~cfg1.gate | pin_sync[3]);

    // source select; timer ticks at the update phase too
    assign tick[0] = run_ok[0] & (cfg0.cnt_sel ? edge_evt[0] : update_strobe);
    assign tick[1] = run_ok[1] & (cfg1.cnt_sel ? edge_evt[1] : update_strobe);

    // unit 0 next count and overflows
    always_comb begin
        next_cnt0 = cnt0;
        ovf0_low  = 1'b0;
        ovf0_high = 1'b0;
        unique case (cfg0.mode)
            DTC_MODE_13BIT: begin
                // top three low bits left as they were
                if (tick[0]) begin
                    next_cnt0.low[4:0] = cnt0.low[4:0] + 5'h1;
                    if (&cnt0.low[4:0]) begin
                        next_cnt0.high = cnt0.high + 8'h1;
                        ovf0_low       = &cnt0.high;
                    end
                end
            end
            DTC_MODE_16BIT: begin
                if (tick[0]) begin
                    next_cnt0 = cnt0 + 16'h1;
                    ovf0_low  = &cnt0;
                end
            end
            DTC_MODE_RELOAD: begin
                if (tick[0]) begin
                    next_cnt0.low = (&cnt0.low) ? cnt0.high : cnt0.low + 8'h1;
                    ovf0_low      = &cnt0.low;
                end
            end
            DTC_MODE_SPLIT: begin
                // low on unit 0 controls, high timer on unit 1 run
                if (tick[0]) begin
                    next_cnt0.low = cnt0.low + 8'h1;
                    ovf0_low      = &cnt0.low;
                end
                if (timer_run_control[DTC_RC_U1_RUN] && update_strobe) begin
                    next_cnt0.high = cnt0.high + 8'h1;
                    ovf0_high      = &cnt0.high;
                end
            end
        endcase
    end

    // unit 1 next count and overflow
    always_comb begin
        next_cnt1 = cnt1;
        ovf1      = 1'b0;
        unique case (cfg1.mode)
            DTC_MODE_13BIT: begin
                if (tick[1]) begin
                    next_cnt1.low[4:0] = cnt1.low[4:0] + 5'h1;
                    if (&cnt1.low[4:0]) begin
                        next_cnt1.high = cnt1.high + 8'h1;
                        ovf1           = &cnt1.high;
                    end
                end
            end
            DTC_MODE_16BIT: begin
                if (tick[1]) begin
                    next_cnt1 = cnt1 + 16'h1;
                    ovf1      = &cnt1;
                end
            end
            DTC_MODE_RELOAD: begin
                if (tick[1]) begin
                    next_cnt1.low = (&cnt1.low) ? cnt1.high : cnt1.low + 8'h1;
                    ovf1          = &cnt1.low;
                end
            end
            DTC_MODE_SPLIT: begin
                next_cnt1 = cnt1;
            end
        endcase
    end

    // bus decode: word index is the register index
    assign word_idx = wb_adr_i[11:2];
    assign mapped   = (word_idx == {2'b00, DTC_IDX_RUN_CONTROL}) || (word_idx == {2'b00, DTC_IDX_MODE_CONFIG}) ||
                      (word_idx == {2'b00, DTC_IDX_U0_LOW})      || (word_idx == {2'b00, DTC_IDX_U1_LOW}) ||
                      (word_idx == {2'b00, DTC_IDX_U0_HIGH})     || (word_idx == {2'b00, DTC_IDX_U1_HIGH}) ||
                      (word_idx == {2'b00, DTC_IDX_IRQ_STATUS})  || (word_idx == {2'b00, DTC_IDX_IRQ_ENABLE}) ||
                      (word_idx == {2'b00, DTC_IDX_IRQ_CLEAR});
    // only byte lane 0 carries data; ack not yet high avoids a double write
    assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & ~wb_err_o & mapped & wb_sel_i[0];
    assign rd_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;

    function automatic logic wr_to(input logic [9:0] idx, input logic [7:0] reg_idx);
        wr_to = (idx == {2'b00, reg_idx});
    endfunction

    // count registers: software write beats counting in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt0 <= {DTC_COUNT_RST, DTC_COUNT_RST};
            cnt1 <= {DTC_COUNT_RST, DTC_COUNT_RST};
        end else begin
            cnt0 <= next_cnt0;
            cnt1 <= next_cnt1;
            if (wr_hit && wr_to(word_idx, DTC_IDX_U0_LOW))  cnt0.low  <= wb_dat_i[7:0];
            if (wr_hit && wr_to(word_idx, DTC_IDX_U0_HIGH)) cnt0.high <= wb_dat_i[7:0];
            if (wr_hit && wr_to(word_idx, DTC_IDX_U1_LOW))  cnt1.low  <= wb_dat_i[7:0];
            if (wr_hit && wr_to(word_idx, DTC_IDX_U1_HIGH)) cnt1.high <= wb_dat_i[7:0];
        end
    end

    // mode config register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_mode_config <= DTC_MODE_CONFIG_RST;
        end else if (wr_hit && wr_to(word_idx, DTC_IDX_MODE_CONFIG)) begin
            timer_mode_config <= wb_dat_i[7:0];
        end
    end

    // control layout, low nibble reserved here
    // overflow sets, vector clears; set wins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_run_control <= DTC_RUN_CONTROL_RST;
        end else begin
            if (wr_hit && wr_to(word_idx, DTC_IDX_RUN_CONTROL)) begin
                timer_run_control[7:4] <= wb_dat_i[7:4];
            end else begin
                if (vector_ack_zero) timer_run_control[DTC_RC_U0_OVF] <= 1'b0;
                if (vector_ack_one)  timer_run_control[DTC_RC_U1_OVF] <= 1'b0;
            end
            if (ovf0_low)              timer_run_control[DTC_RC_U0_OVF] <= 1'b1;
            if (ovf0_high || ovf1)     timer_run_control[DTC_RC_U1_OVF] <= 1'b1;
            timer_run_control[3:0] <= 4'h0;
        end
    end

    // sticky status, write-one clear; a new overflow beats the clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= 2'b00;
            irq_enable <= 2'b00;
        end else begin
            if (wr_hit && wr_to(word_idx, DTC_IDX_IRQ_ENABLE)) irq_enable <= wb_dat_i[1:0];
            irq_status <= (irq_status & ~((wr_hit && wr_to(word_idx, DTC_IDX_IRQ_CLEAR)) ? wb_dat_i[1:0] : 2'b00))
                          | {ovf0_high | ovf1, ovf0_low};
        end
    end

    // read mux
    always_comb begin
        rd_byte = 8'h00;
        unique case (word_idx)
            {2'b00, DTC_IDX_RUN_CONTROL}: rd_byte = timer_run_control;
            {2'b00, DTC_IDX_MODE_CONFIG}: rd_byte = timer_mode_config;
            {2'b00, DTC_IDX_U0_LOW}:      rd_byte = cnt0.low;
            {2'b00, DTC_IDX_U1_LOW}:      rd_byte = cnt1.low;
            {2'b00, DTC_IDX_U0_HIGH}:     rd_byte = cnt0.high;
            {2'b00, DTC_IDX_U1_HIGH}:     rd_byte = cnt1.high;
            {2'b00, DTC_IDX_IRQ_STATUS}:  rd_byte = {6'h00, irq_status};
            {2'b00, DTC_IDX_IRQ_ENABLE}:  rd_byte = {6'h00, irq_enable};
            default:                      rd_byte = 8'h00;
        endcase
    end

    // bus answer one cycle after the request, dropped the next cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= rd_hit & mapped;
            wb_err_o <= rd_hit & ~mapped;
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // registered copies of flags and interrupt
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            unit0_overflow_flag <= 1'b0;
            unit1_overflow_flag <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            unit0_overflow_flag <= timer_run_control[DTC_RC_U0_OVF];
            unit1_overflow_flag <= timer_run_control[DTC_RC_U1_OVF];
            irq                 <= |(irq_status & irq_enable);
        end
    end
endmodule

// ---- tb/dtc_timer_pair_checker.sv ----
// bus and overflow-flag assertions for the timer pair
// assumes one clock domain; bound to dtc_timer_pair by port names
`timescale 1ns/100ps
module dtc_timer_pair_checker
    import dtc_pkg::*;
(
    input wire logic        clock,
    input wire logic        arst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        vector_ack_zero,
    input wire logic        unit0_overflow_flag
);
    logic       req;
    logic       mapped;
    logic [9:0] idx;
    // request taken at this edge, and its address decode
    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign idx    = wb_adr_i[11:2];
    assign mapped = (idx >= 10'h088 && idx <= 10'h08d) || (idx >= 10'h090 && idx <= 10'h092);

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    chk_ack_mapped: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
        else $error("mapped access not acknowledged next cycle");
    chk_err_unmapped: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused next cycle");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
        else $error("answer without a request");
    chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper lanes not zero");
    chk_control_low: assert property (req && !wb_we_i && idx == {2'b00, DTC_IDX_RUN_CONTROL} |=> wb_dat_o[3:0] == 4'h0)
        else $error("control register low bits not zero");
    chk_vector_clear: assert property (vector_ack_zero && unit0_overflow_flag && !wb_cyc_i |-> ##2 !unit0_overflow_flag)
        else $error("vectoring did not clear overflow flag");
    chk_flag_hold: assert property ($fell(unit0_overflow_flag) |-> $past(vector_ack_zero, 2) || $past(wb_cyc_i, 2))
        else $error("overflow flag cleared without cause");
endmodule

bind dtc_timer_pair dtc_timer_pair_checker dtc_timer_pair_checker_inst (
    .clock               (clock),
    .arst_n              (arst_n),
    .wb_cyc_i            (wb_cyc_i),
    .wb_stb_i            (wb_stb_i),
    .wb_we_i             (wb_we_i),
    .wb_adr_i            (wb_adr_i),
    .wb_dat_o            (wb_dat_o),
    .wb_ack_o            (wb_ack_o),
    .wb_err_o            (wb_err_o),
    .vector_ack_zero     (vector_ack_zero),
    .unit0_overflow_flag (unit0_overflow_flag)
);

// ---- tb/dtc_pin_model.sv ----
// pin source for the timer pair: count pulse bursts and gate levels
// assumes pulled-up port pins, so count pins idle high
`timescale 1ns/100ps
module dtc_pin_model
    import dtc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       start,
    input  wire logic [7:0] pulses,
    input  wire logic [7:0] half,
    input  wire logic [1:0] gate_level,
    output logic            count_pin_zero,
    output logic            count_pin_one,
    output logic            gate_pin_zero,
    output logic            gate_pin_one,
    output logic            busy
);
    logic level;
    // gate pins follow requested levels; both count pins share a burst
    assign gate_pin_zero  = gate_level[0];
    assign gate_pin_one   = gate_level[1];
    assign count_pin_zero = level;
    assign count_pin_one  = level;
    initial begin
        level = 1'b1;
        busy  = 1'b0;
        forever begin
            @(posedge clock);
            if (start) begin
                busy <= 1'b1;
                repeat (pulses) begin
                    level <= 1'b0;
                    repeat (half) @(posedge clock);
                    level <= 1'b1;
                    repeat (half) @(posedge clock);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the dual timer/counter pair
// assumes the pin model and the bound checker are compiled alongside
`timescale 1ns/100ps
module tb_top
    import dtc_pkg::*;
();
    localparam logic [7:0] RC = DTC_IDX_RUN_CONTROL;
    localparam logic [7:0] MC = DTC_IDX_MODE_CONFIG;
    localparam logic [7:0] L0 = DTC_IDX_U0_LOW;
    localparam logic [7:0] H0 = DTC_IDX_U0_HIGH;
    logic        clock, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, irq;
    logic [11:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [3:0]  wb_sel_i;
    logic        count_pin_zero, count_pin_one, gate_pin_zero, gate_pin_one;
    logic        vector_ack_zero, vector_ack_one, unit0_overflow_flag, unit1_overflow_flag;
    logic        pm_start, pm_busy;
    logic [7:0]  pm_pulses, pm_half;
    logic [1:0]  pm_gate;
    int          fail_count, checked, cycles;

    dtc_timer_pair dtc_timer_pair_inst (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one), .gate_pin_zero(gate_pin_zero),
        .gate_pin_one(gate_pin_one), .vector_ack_zero(vector_ack_zero), .vector_ack_one(vector_ack_one),
        .unit0_overflow_flag(unit0_overflow_flag), .unit1_overflow_flag(unit1_overflow_flag), .irq(irq));
    dtc_pin_model dtc_pin_model_inst (.clock(clock), .start(pm_start), .pulses(pm_pulses), .half(pm_half),
        .gate_level(pm_gate), .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
        .gate_pin_zero(gate_pin_zero), .gate_pin_one(gate_pin_one), .busy(pm_busy));

    // clock and cycle count; the ceiling is well above the roughly one thousand cycles needed
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    // one classic cycle, entered just after an edge; holds until ack or err
    task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd,
                        output logic err);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {2'b00, idx, 2'b00};
        wb_dat_i <= {24'h0, wd};
        do @(posedge clock); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o[7:0];
        err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        logic [7:0] d;
        logic       e;
        xfer(1'b1, idx, v, d, e);
    endtask

    task automatic rdc(input string name, input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        logic       e;
        xfer(1'b0, idx, 8'h00, d, e);
        check(name, exp, d);
    endtask

    // run and stop writes start at the same machine-cycle phase, so exactly k ticks land
    task automatic run_for(input int k, input logic [7:0] runv, input logic [7:0] stopv);
        int t;
        t = cycles;
        wr(RC, runv);
        while (cycles != t + 12 * k) @(posedge clock);
        wr(RC, stopv);
    endtask

    task automatic t_regs();
        logic [7:0] d;
        logic       e;
        rdc("run_control", RC, 8'h00);
        rdc("mode_config", MC, 8'h00);
        wr(MC, 8'ha5);
        rdc("mode_config", MC, 8'ha5);
        // write without lane 0 is acked but must not land
        wb_sel_i <= 4'he;
        wr(MC, 8'h00);
        wb_sel_i <= 4'hf;
        rdc("mode_config", MC, 8'ha5);
        wr(RC, 8'hff);
        rdc("run_control", RC, 8'hf0);
        wr(RC, 8'h00);
        xfer(1'b0, 8'hff, 8'h00, d, e);
        check("unmapped err", 8'h01, {7'h0, e});
        $display("test regs done");
    endtask

    task automatic t_modes();
        wr(MC, 8'h01);
        wr(L0, 8'hfe);
        wr(H0, 8'h12);
        run_for(5, 8'h10, 8'h00);
        rdc("u0 low", L0, 8'h03);
        rdc("u0 high", H0, 8'h13);
        repeat (24) @(posedge clock);
        rdc("u0 low stopped", L0, 8'h03);
        wr(MC, 8'h00);
        wr(L0, 8'h1e);
        wr(H0, 8'h00);
        run_for(3, 8'h10, 8'h00);
        rdc("prescale low", L0, 8'h01);
        rdc("prescale high", H0, 8'h01);
        wr(MC, 8'h30);
        wr(DTC_IDX_U1_LOW, 8'h00);
        run_for(3, 8'h40, 8'h00);
        rdc("u1 stopped", DTC_IDX_U1_LOW, 8'h00);
        wr(MC, 8'h03);
        wr(L0, 8'h00);
        wr(H0, 8'h00);
        run_for(4, 8'h40, 8'h00);
        rdc("split high", H0, 8'h04);
        rdc("split low", L0, 8'h00);
        run_for(2, 8'h10, 8'h00);
        rdc("split low run", L0, 8'h02);
        $display("test modes done");
    endtask

    task automatic t_reload();
        wr(DTC_IDX_IRQ_CLEAR, 8'h03);
        wr(MC, 8'h02);
        wr(H0, 8'hfc);
        wr(L0, 8'hfe);
        run_for(3, 8'h10, 8'h20);
        rdc("reload low", L0, 8'hfd);
        rdc("reload high", H0, 8'hfc);
        rdc("irq status", DTC_IDX_IRQ_STATUS, 8'h01);
        wr(DTC_IDX_IRQ_ENABLE, 8'h01);
        repeat (2) @(posedge clock);
        check("irq enabled", 8'h01, {7'h0, irq});
        wr(DTC_IDX_IRQ_ENABLE, 8'h00);
        repeat (2) @(posedge clock);
        check("irq masked", 8'h00, {7'h0, irq});
        wr(DTC_IDX_IRQ_ENABLE, 8'h01);
        wr(DTC_IDX_IRQ_CLEAR, 8'h01);
        repeat (2) @(posedge clock);
        check("irq cleared", 8'h00, {7'h0, irq});
        rdc("irq status", DTC_IDX_IRQ_STATUS, 8'h00);
        check("flag out", 8'h01, {7'h0, unit0_overflow_flag});
        vector_ack_zero <= 1'b1;
        @(posedge clock);
        vector_ack_zero <= 1'b0;
        @(posedge clock);
        rdc("flag vectored", RC, 8'h00);
        // split high byte rolls over into unit 1's flag, then vectoring clears it
        wr(MC, 8'h03);
        wr(H0, 8'hff);
        wr(RC, 8'h40);
        repeat (30) @(posedge clock);
        check("u1 flag out", 8'h01, {7'h0, unit1_overflow_flag});
        vector_ack_one <= 1'b1;
        @(posedge clock);
        vector_ack_one <= 1'b0;
        repeat (2) @(posedge clock);
        check("u1 flag vectored", 8'h00, {7'h0, unit1_overflow_flag});
        wr(RC, 8'h00);
        $display("test reload done");
    endtask

    task automatic burst(input logic [7:0] n, input logic [7:0] h);
        pm_pulses <= n;
        pm_half   <= h;
        pm_start  <= 1'b1;
        @(posedge clock);
        pm_start <= 1'b0;
        @(posedge clock);
        while (pm_busy) @(posedge clock);
    endtask

    task automatic t_pins();
        wr(MC, 8'h09);
        wr(L0, 8'h00);
        wr(H0, 8'h00);
        pm_gate <= 2'b10;
        repeat (4) @(posedge clock);
        run_for(4, 8'h10, 8'h00);
        rdc("gated low", L0, 8'h00);
        pm_gate <= 2'b11;
        repeat (4) @(posedge clock);
        run_for(4, 8'h10, 8'h00);
        rdc("gate open", L0, 8'h04);
        wr(MC, 8'h55);
        wr(L0, 8'h00);
        wr(DTC_IDX_U1_LOW, 8'h00);
        wr(RC, 8'h50);
        burst(8'd5, 8'd12);
        burst(8'd3, 8'd30);
        repeat (36) @(posedge clock);
        wr(RC, 8'h00);
        rdc("u0 events", L0, 8'h08);
        rdc("u1 events", DTC_IDX_U1_LOW, 8'h08);
        $display("test pins done");
    endtask

    initial begin
        {arst_n, wb_cyc_i, wb_stb_i, wb_we_i, vector_ack_zero, vector_ack_one, pm_start} = '0;
        {wb_adr_i, wb_dat_i, pm_pulses} = '0;
        wb_sel_i = 4'hf;
        pm_half = 8'd12;
        pm_gate = 2'b11;
        {fail_count, checked, cycles} = '0;
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        repeat (3) @(posedge clock);
        t_regs();
        t_modes();
        t_reload();
        t_pins();
        finish_test();
    end
endmodule
